// *** rtl/rfdrv_cfg.sv ***
// Driver resistance and transient timing config bank with auto acquisition
`timescale 1ns/10ps
`include "rfdrv_params.svh"

module rfdrv_cfg (
    // Clock and reset
    input  wire logic                     clock,
    input  wire logic                     nrst,
    // Register port
    input  wire logic [`RFDRV_ADDR_W-1:0] addr,
    input  wire logic [7:0]               wdata,
    input  wire logic                     wr,
    input  wire logic                     rd,
    output logic      [7:0]               rdata,
    // Driver side
    input  wire logic                     drv_en,
    input  wire logic                     lm_mod,
    input  wire logic                     rf_tick,
    input  wire logic [3:0]               meas_ratio,
    // Driver settings
    output logic      [3:0]               modulated_state_resistance,
    output logic      [3:0]               unmodulated_state_resistance,
    output logic      [3:0]               load_mod_res_code,
    output logic                          rf_driver_output_hiz,
    output logic      [2:0]               drv_timing,
    output logic                          acq_busy
);

    rfdrv_pkg::rfdrv_state_s state_q;
    rfdrv_pkg::rfdrv_state_s state_d;

    logic       acq_start;
    logic       auto_sel;
    logic       man_top;
    logic [3:0] target;
    logic [3:0] mod_code;
    logic [3:0] unmod_code;

    assign auto_sel   = ~state_q.tim_reg[`RFDRV_MAN_BIT];
    assign man_top    = state_q.tim_reg[`RFDRV_MSEL_TOP];
    assign target     = state_q.tim_reg[`RFDRV_RAT_MSB:`RFDRV_RAT_LSB];
    assign mod_code   = state_q.pt_reg[`RFDRV_MOD_MSB:`RFDRV_MOD_LSB];
    assign unmod_code = state_q.pt_reg[`RFDRV_UNMOD_MSB:`RFDRV_UNMOD_LSB];
    assign acq_start  = drv_en & ~state_q.drv_en_prev & auto_sel;

    always_comb begin
        state_d             = state_q;
        state_d.rdata       = 8'h00;
        state_d.drv_en_prev = drv_en;

        if (wr) begin
            case (addr)
                `RFDRV_PT_ADDR: begin
                    state_d.pt_reg = wdata;
                end
                `RFDRV_TIM_ADDR: begin
                    state_d.tim_reg = wdata;
                end
                default: begin
                end
            endcase
        end

        // Unmapped space reads as zero, read-only status reads its flags and step
        if (rd) begin
            case (addr)
                `RFDRV_PT_ADDR: begin
                    state_d.rdata = state_q.pt_reg;
                end
                `RFDRV_TIM_ADDR: begin
                    state_d.rdata = state_q.tim_reg;
                end
                `RFDRV_STAT_ADDR: begin
                    state_d.rdata = {3'h0, state_q.acq_met, state_q.acq != rfdrv_pkg::ACQ_IDLE,
                                     state_q.acq_step};
                end
                default: begin
                    state_d.rdata = 8'h00;
                end
            endcase
        end

        case (state_q.acq)
            rfdrv_pkg::ACQ_IDLE: begin
                if (acq_start) begin
                    state_d.acq      = rfdrv_pkg::ACQ_SETTLE;
                    state_d.acq_step = `RFDRV_STEP_SLOW;
                    state_d.acq_met  = 1'b0;
                end
            end
            rfdrv_pkg::ACQ_SETTLE: begin
                // One RF period to settle, so two periods per step
                if (!drv_en) begin
                    state_d.acq = rfdrv_pkg::ACQ_IDLE;
                end else if (rf_tick) begin
                    state_d.acq = rfdrv_pkg::ACQ_MEASURE;
                end
            end
            rfdrv_pkg::ACQ_MEASURE: begin
                if (!drv_en) begin
                    state_d.acq = rfdrv_pkg::ACQ_IDLE;
                end else if (rf_tick) begin
                    // Hold first setting that reaches target
                    if (meas_ratio >= target) begin
                        state_d.acq     = rfdrv_pkg::ACQ_IDLE;
                        state_d.acq_met = 1'b1;
                    // Fast is the last of five steps
                    end else if (state_q.acq_step == `RFDRV_STEP_FAST) begin
                        state_d.acq = rfdrv_pkg::ACQ_IDLE;
                    end else begin
                        state_d.acq      = rfdrv_pkg::ACQ_SETTLE;
                        state_d.acq_step = state_q.acq_step + 3'h1;
                    end
                end
            end
            default: begin
                state_d.acq = rfdrv_pkg::ACQ_IDLE;
            end
        endcase

        if (!auto_sel) begin
            // Manual code, any top bit gives fast
            state_d.timing = man_top ? `RFDRV_STEP_FAST
                           : {1'b0, state_q.tim_reg[`RFDRV_MSEL_MSB:`RFDRV_MSEL_LSB]};
        end else begin
            state_d.timing = state_q.acq_step;
        end

        state_d.res_code = lm_mod ? mod_code : unmod_code;
        state_d.res_hiz  = (state_d.res_code == `RFDRV_HIZ_CODE);
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_q             <= '0;
            state_q.pt_reg      <= `RFDRV_PT_RESET;
            state_q.tim_reg     <= `RFDRV_TIM_RESET;
            state_q.acq         <= rfdrv_pkg::ACQ_IDLE;
            state_q.acq_step    <= `RFDRV_STEP_SLOW;
            state_q.timing      <= `RFDRV_STEP_FAST;
        end else begin
            state_q <= state_d;
        end
    end

    assign rdata                        = state_q.rdata;
    assign modulated_state_resistance   = mod_code;
    assign unmodulated_state_resistance = unmod_code;
    assign load_mod_res_code            = state_q.res_code;
    assign rf_driver_output_hiz         = state_q.res_hiz;
    assign drv_timing                   = state_q.timing;
    assign acq_busy                     = state_q.acq != rfdrv_pkg::ACQ_IDLE;

    // RF periods spent in one acquisition, for checking only
    logic [4:0] per_cnt_q;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            per_cnt_q <= 5'h00;
        end else if (acq_start) begin
            per_cnt_q <= 5'h00;
        end else if (acq_busy && rf_tick && per_cnt_q != 5'h1f) begin
            per_cnt_q <= per_cnt_q + 5'h01;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    a_mod_res_write: assert property (
        wr && addr == `RFDRV_PT_ADDR |=> modulated_state_resistance == $past(wdata[7:4]))
        else $error("modulated code not taken from upper nibble");

    a_unmod_res_write: assert property (
        wr && addr == `RFDRV_PT_ADDR |=> unmodulated_state_resistance == $past(wdata[3:0]))
        else $error("unmodulated code not taken from lower nibble");

    a_hiz_code_map: assert property (
        lm_mod && mod_code == 4'hf |=> rf_driver_output_hiz && load_mod_res_code == 4'hf)
        else $error("code 15 did not float the driver");

    a_target_field_write: assert property (
        wr && addr == `RFDRV_TIM_ADDR |=> target == $past(wdata[7:4]))
        else $error("target ratio not taken from upper nibble");

    a_acq_start_slow: assert property (
        acq_start |=> state_q.acq == rfdrv_pkg::ACQ_SETTLE && state_q.acq_step == 3'h0)
        else $error("acquisition did not start at slowest step");

    a_step_faster: assert property (
        drv_en && state_q.acq == rfdrv_pkg::ACQ_MEASURE && rf_tick && meas_ratio < target
        && state_q.acq_step != 3'h4
        |=> state_q.acq_step == $past(state_q.acq_step) + 3'h1 && acq_busy)
        else $error("low ratio did not step faster");

    a_stop_on_target: assert property (
        drv_en && state_q.acq == rfdrv_pkg::ACQ_MEASURE && rf_tick && meas_ratio >= target
        |=> !acq_busy && state_q.acq_met && $stable(state_q.acq_step))
        else $error("acquisition did not hold on target");

    a_acq_period_bound: assert property (
        acq_busy |-> per_cnt_q < `RFDRV_ACQ_MAX_PER && state_q.acq_step <= 3'h4)
        else $error("acquisition ran past ten RF periods");

    a_auto_source: assert property (
        auto_sel && $stable(state_q.tim_reg) |=> drv_timing == $past(state_q.acq_step))
        else $error("auto mode not using acquired setting");

    a_manual_code: assert property (
        !auto_sel && $stable(state_q.tim_reg)
        |=> drv_timing == ($past(man_top) ? 3'h4 : {1'b0, $past(state_q.tim_reg[1:0])}))
        else $error("manual timing code misdecoded");

    a_enable_restart: assert property (
        drv_en && !state_q.drv_en_prev && auto_sel |=> acq_busy)
        else $error("driver enable did not restart acquisition");

    a_pt_readback: assert property (
        rd && addr == `RFDRV_PT_ADDR |=> rdata == $past(state_q.pt_reg))
        else $error("passive target register read back wrong");

    a_tim_readback: assert property (
        rd && addr == `RFDRV_TIM_ADDR |=> rdata == $past(state_q.tim_reg))
        else $error("timing register read back wrong");

    a_status_readback: assert property (
        rd && addr == `RFDRV_STAT_ADDR
        |=> rdata == {3'h0, $past(state_q.acq_met), $past(acq_busy), $past(state_q.acq_step)})
        else $error("status read back wrong");

    a_rdata_idle: assert property (
        !rd |=> rdata == 8'h00)
        else $error("read data stood longer than one cycle");

    a_tim_write: assert property (
        wr && addr == `RFDRV_TIM_ADDR |=> state_q.tim_reg == $past(wdata))
        else $error("timing register write lost");

    a_pt_hold: assert property (
        !(wr && addr == `RFDRV_PT_ADDR) |=> $stable(state_q.pt_reg))
        else $error("passive target register changed without a write");

    a_mod_select: assert property (
        lm_mod |=> load_mod_res_code == $past(mod_code))
        else $error("modulated state did not apply its code");

    a_unmod_select: assert property (
        !lm_mod |=> load_mod_res_code == $past(unmod_code))
        else $error("unmodulated state did not apply its code");

    a_hiz_flag_match: assert property (
        rf_driver_output_hiz == (load_mod_res_code == 4'hf))
        else $error("high impedance flag disagrees with applied code");

    a_settle_no_step: assert property (
        state_q.acq == rfdrv_pkg::ACQ_SETTLE |=> $stable(state_q.acq_step))
        else $error("step moved while settling");

    a_busy_no_tick: assert property (
        acq_busy && drv_en && !rf_tick |=> acq_busy && $stable(state_q.acq_step))
        else $error("acquisition moved without an RF period");

    a_met_cleared_start: assert property (
        acq_start |=> !state_q.acq_met)
        else $error("target flag not cleared on new acquisition");

    a_fail_keeps_fast: assert property (
        drv_en && state_q.acq == rfdrv_pkg::ACQ_MEASURE && rf_tick && meas_ratio < target
        && state_q.acq_step == 3'h4
        |=> !acq_busy && !state_q.acq_met && state_q.acq_step == 3'h4)
        else $error("failed acquisition did not keep fast setting");

    a_manual_no_start: assert property (
        !auto_sel && !acq_busy |=> !acq_busy)
        else $error("acquisition started in manual mode");

    a_abort_on_disable: assert property (
        acq_busy && !drv_en |=> !acq_busy)
        else $error("driver disable did not abandon acquisition");

    c_acq_met: cover property (
        state_q.acq == rfdrv_pkg::ACQ_MEASURE ##1 state_q.acq_met && !acq_busy);
    c_acq_to_fast: cover property (acq_busy && state_q.acq_step == 3'h4 ##1 !acq_busy);
    c_manual_fast: cover property (!auto_sel && man_top && drv_timing == 3'h4);
    c_hiz_modulated: cover property (rf_driver_output_hiz && lm_mod);
    c_acq_abort: cover property (acq_busy && !drv_en ##1 !acq_busy);

endmodule

// *** inc/rfdrv_params.svh ***
// Offsets, field positions, reset values and counts of the driver config bank
`ifndef RFDRV_PARAMS_SVH
`define RFDRV_PARAMS_SVH

// Address bit 8 selects register space B
`define RFDRV_ADDR_W        9
`define RFDRV_PT_ADDR       9'h029
`define RFDRV_TIM_ADDR      9'h129
`define RFDRV_STAT_ADDR     9'h12b

`define RFDRV_PT_RESET      8'h70
`define RFDRV_TIM_RESET     8'h7c

`define RFDRV_MOD_MSB       7
`define RFDRV_MOD_LSB       4
`define RFDRV_UNMOD_MSB     3
`define RFDRV_UNMOD_LSB     0
`define RFDRV_RAT_MSB       7
`define RFDRV_RAT_LSB       4
`define RFDRV_MAN_BIT       3
`define RFDRV_MSEL_TOP      2
`define RFDRV_MSEL_MSB      1
`define RFDRV_MSEL_LSB      0

`define RFDRV_STAT_BUSY     3
`define RFDRV_STAT_MET      4

`define RFDRV_HIZ_CODE      4'hf
`define RFDRV_STEP_SLOW     3'h0
`define RFDRV_STEP_FAST     3'h4
`define RFDRV_ACQ_MAX_PER   5'h0a

`endif

// *** inc/rfdrv_pkg.sv ***
// Types of the driver resistance and timing config bank
package rfdrv_pkg;

    typedef enum logic [1:0] {
        ACQ_IDLE,
        ACQ_SETTLE,
        ACQ_MEASURE
    } rfdrv_acq_e;

    typedef struct packed {
        logic [7:0] pt_reg;
        logic [7:0] tim_reg;
        rfdrv_acq_e acq;
        logic [2:0] acq_step;
        logic       acq_met;
        logic       drv_en_prev;
        logic [7:0] rdata;
        logic [3:0] res_code;
        logic       res_hiz;
        logic [2:0] timing;
    } rfdrv_state_s;

endpackage

// *** sim/rfdrv_cfg_tb.sv ***
// Self-checking bench of the driver resistance and timing config bank
`timescale 1ns/10ps
`include "rfdrv_params.svh"
module rfdrv_cfg_tb;
    logic                     clock = 1'b0;
    logic                     nrst = 1'b0;
    logic [`RFDRV_ADDR_W-1:0] addr = 9'h000;
    logic [7:0]               wdata = 8'h00;
    logic                     wr = 1'b0;
    logic                     rd = 1'b0;
    logic [7:0]               rdata;
    logic                     drv_en = 1'b0;
    logic                     lm_mod = 1'b0;
    logic                     rf_tick = 1'b0;
    logic [3:0]               meas_ratio = 4'h0;
    logic [3:0]               mod_res;
    logic [3:0]               unmod_res;
    logic [3:0]               lm_code;
    logic                     hiz;
    logic [2:0]               drv_timing;
    logic                     acq_busy;
    int                       fail_count = 0;
    int                       checked = 0;

    always #20 clock = ~clock;

    rfdrv_cfg dut (
        .clock                        (clock),
        .nrst                         (nrst),
        .addr                         (addr),
        .wdata                        (wdata),
        .wr                           (wr),
        .rd                           (rd),
        .rdata                        (rdata),
        .drv_en                       (drv_en),
        .lm_mod                       (lm_mod),
        .rf_tick                      (rf_tick),
        .meas_ratio                   (meas_ratio),
        .modulated_state_resistance   (mod_res),
        .unmodulated_state_resistance (unmod_res),
        .load_mod_res_code            (lm_code),
        .rf_driver_output_hiz         (hiz),
        .drv_timing                   (drv_timing),
        .acq_busy                     (acq_busy)
    );

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic cmp(string name, logic [7:0] got, logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr_reg(logic [8:0] a, logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        @(posedge clock);
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(logic [8:0] a, logic [7:0] exp, string name);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        cmp(name, rdata, exp);
        @(posedge clock);
        #1;
        cmp("rdata idle", rdata, 8'h00);
    endtask

    task automatic t_reset();
        rd_reg(`RFDRV_PT_ADDR, 8'h70, "pt reset");
        rd_reg(`RFDRV_TIM_ADDR, 8'h7c, "tim reset");
        rd_reg(9'h0ff, 8'h00, "unmapped");
        cmp("mod reset", 8'(mod_res), 8'h07);
        cmp("unmod reset", 8'(unmod_res), 8'h00);
        cmp("timing reset", 8'(drv_timing), 8'h04);
        wr_reg(`RFDRV_STAT_ADDR, 8'hff);
        rd_reg(`RFDRV_STAT_ADDR, 8'h00, "status ro");
        @(posedge clock);
        drv_en <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
        cmp("manual no acq", 8'(acq_busy), 8'h00);
        @(posedge clock);
        drv_en <= 1'b0;
    endtask

    task automatic t_res();
        wr_reg(`RFDRV_PT_ADDR, 8'h5f);
        cmp("mod", 8'(mod_res), 8'h05);
        cmp("unmod", 8'(unmod_res), 8'h0f);
        @(posedge clock);
        #1;
        cmp("code unmod", 8'(lm_code), 8'h0f);
        cmp("hiz on", 8'(hiz), 8'h01);
        @(posedge clock);
        lm_mod <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        cmp("code mod", 8'(lm_code), 8'h05);
        cmp("hiz off", 8'(hiz), 8'h00);
        rd_reg(`RFDRV_PT_ADDR, 8'h5f, "pt rw");
        wr_reg(`RFDRV_PT_ADDR, 8'hf0);
        @(posedge clock);
        #1;
        cmp("code mod hiz", 8'(lm_code), 8'h0f);
        cmp("hiz mod", 8'(hiz), 8'h01);
        @(posedge clock);
        lm_mod <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        cmp("code unmod zero", 8'(lm_code), 8'h00);
        cmp("hiz unmod", 8'(hiz), 8'h00);
    endtask

    task automatic t_manual();
        logic [3:0] m;
        for (m = 4'h0; m < 4'h8; m++) begin
            wr_reg(`RFDRV_TIM_ADDR, {4'h9, 1'b1, m[2:0]});
            @(posedge clock);
            #1;
            cmp("manual timing", 8'(drv_timing), m[2] ? 8'h04 : 8'(m[1:0]));
        end
        rd_reg(`RFDRV_TIM_ADDR, 8'h9f, "tim rw");
    endtask

    // Ratio seen rises with speed, so a target picks the stopping step
    task automatic t_acq(logic [3:0] tgt, logic [7:0] stat, int ticks);
        int         n;
        logic [3:0] r;
        wr_reg(`RFDRV_TIM_ADDR, {tgt, 4'h0});
        @(posedge clock);
        drv_en <= 1'b1;
        @(posedge clock);
        #1;
        cmp("acq start", 8'(acq_busy), 8'h01);
        for (n = 0; n < 12 && acq_busy === 1'b1; n++) begin
            r = {1'b0, drv_timing} + 4'h1;
            if (n == 1) begin
                cmp("first step", 8'(drv_timing), 8'h00);
            end
            @(posedge clock);
            rf_tick <= 1'b1;
            meas_ratio <= r;
            @(posedge clock);
            rf_tick <= 1'b0;
            @(posedge clock);
            #1;
        end
        cmp("acq ticks", 8'(n), 8'(ticks));
        cmp("acq timing", 8'(drv_timing), 8'(stat[2:0]));
        rd_reg(`RFDRV_STAT_ADDR, stat, "status");
        @(posedge clock);
        drv_en <= 1'b0;
    endtask

    // Dropping the enable abandons a running acquisition
    task automatic t_abort();
        wr_reg(`RFDRV_TIM_ADDR, 8'hf0);
        @(posedge clock);
        drv_en <= 1'b1;
        rd_reg(`RFDRV_STAT_ADDR, 8'h08, "status busy");
        @(posedge clock);
        drv_en <= 1'b0;
        @(posedge clock);
        #1;
        cmp("abort idle", 8'(acq_busy), 8'h00);
        cmp("abort step", 8'(drv_timing), 8'h00);
    endtask

    initial begin
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        t_reset();
        t_res();
        t_manual();
        t_acq(4'h3, 8'h12, 6);
        t_acq(4'hf, 8'h04, 10);
        t_abort();
        end_sim();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clock);
        fail_count++;
        end_sim();
    end
endmodule
